// file: core/dcd_pkg.sv
// dcd_pkg: constants, encodings and carrier types of the command decoder
// assumes: included before every dcd_* module; nothing imported
package dcd_pkg;

    localparam int DCD_BA_W    = 3;
    localparam int DCD_ADDR_W  = 13;
    localparam int DCD_COL_W   = 12;
    localparam int DCD_BANKS   = 8;
    localparam int DCD_AP_BIT  = 10;
    localparam int DCD_DQ_W    = 16;
    localparam int DCD_LANES   = 2;

    // clocks a length-four burst owns the command bus: BL/2
    localparam int DCD_BL      = 4;
    localparam int DCD_BL_HOLD = DCD_BL / 2 - 1;

    // {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] DCD_ENC_MRS = 4'h0;
    localparam logic [3:0] DCD_ENC_REF = 4'h1;
    localparam logic [3:0] DCD_ENC_PRE = 4'h2;
    localparam logic [3:0] DCD_ENC_ACT = 4'h3;
    localparam logic [3:0] DCD_ENC_WR  = 4'h4;
    localparam logic [3:0] DCD_ENC_RD  = 4'h5;
    localparam logic [3:0] DCD_ENC_NOP = 4'h7;

    typedef enum logic [3:0] {
        DCD_CMD_NOP  = 4'h0,
        DCD_CMD_DSL  = 4'h1,
        DCD_CMD_ACT  = 4'h2,
        DCD_CMD_PRE  = 4'h3,
        DCD_CMD_PREA = 4'h4,
        DCD_CMD_WR   = 4'h5,
        DCD_CMD_WRA  = 4'h6,
        DCD_CMD_RD   = 4'h7,
        DCD_CMD_RDA  = 4'h8,
        DCD_CMD_MRS  = 4'h9,
        DCD_CMD_REF  = 4'ha,
        DCD_CMD_SRE  = 4'hb,
        DCD_CMD_SRX  = 4'hc,
        DCD_CMD_PDE  = 4'hd,
        DCD_CMD_PDX  = 4'he,
        DCD_CMD_ILL  = 4'hf
    } dcd_cmd_type;

    // gray along normal -> pd -> normal; normal -> self -> normal flips both bits
    typedef enum logic [1:0] {
        DCD_PWR_NORMAL = 2'h0,
        DCD_PWR_PD_PRE = 2'h1,
        DCD_PWR_PD_ACT = 2'h2,
        DCD_PWR_SELF   = 2'h3
    } dcd_pwr_type;

    typedef struct packed {
        logic                  cs_n;
        logic                  ras_n;
        logic                  cas_n;
        logic                  we_n;
        logic                  cke;
        logic                  odt;
        logic [DCD_BA_W-1:0]   ba;
        logic [DCD_ADDR_W-1:0] addr;
    } dcd_pins_type;

    typedef struct packed {
        dcd_cmd_type           cmd;
        dcd_pwr_type           pwr;
        logic [DCD_BA_W-1:0]   ba;
        logic [DCD_ADDR_W-1:0] row;
        logic [DCD_COL_W-1:0]  col;
        logic                  ap;
    } dcd_evt_type;

endpackage

// file: core/dcd_sync.sv
// dcd_sync: two-flop level synchroniser, one per bit
// assumes: inputs are levels from another domain or from pins
`timescale 1ns/1ps
`default_nettype none
module dcd_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_nrst,
    // levels
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            meta_q <= '0;
            o_q    <= '0;
        end else begin
            meta_q <= i_d;
            o_q    <= meta_q;
        end
    end
endmodule
`default_nettype wire

// file: core/dcd_wmask.sv
// dcd_wmask: per-lane write enables from the data mask
// assumes: runs on the link clock, beat, data and mask arrive together
`timescale 1ns/1ps
`default_nettype none
module dcd_wmask #(
    parameter int DQ_W  = dcd_pkg::DCD_DQ_W,
    parameter int LANES = dcd_pkg::DCD_LANES
) (
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_nrst,
    // write beat in
    input  wire logic             i_valid,
    input  wire logic [DQ_W-1:0]  i_dq,
    input  wire logic [LANES-1:0] i_dm,
    // qualified beat out
    output logic                  o_valid_q,
    output logic      [DQ_W-1:0]  o_data_q,
    output logic      [LANES-1:0] o_be_q
);
    for (genvar l = 0; l < LANES; l++) begin : g_lane
        wire lane_en = i_valid & ~i_dm[l];
        always_ff @(posedge i_clk or negedge i_nrst) begin
            if (!i_nrst) begin
                o_be_q[l] <= 1'b0;
            end else begin
                o_be_q[l] <= lane_en; // RULE20
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_valid_q <= 1'b0;
            o_data_q  <= '0;
        end else begin
            o_valid_q <= i_valid;
            o_data_q  <= i_dq;
        end
    end

    chk_mask_lane_zero: assert property ( // RULE20
        @(posedge i_clk) disable iff (!i_nrst)
        i_valid && i_dm[0] |=> !o_be_q[0] && o_valid_q)
        else $error("masked lane 0 still enabled");
endmodule
`default_nettype wire

// file: core/dcd_top.sv
// dcd_top: command and clock-enable decoder of the memory device
// assumes: pins sampled on i_lclk (the memory clock, may stop in self
// refresh); decoded events cross to i_mclk, whose period is well under
// half of i_lclk's
`timescale 1ns/1ps
`default_nettype none
// How it works
// [RULE1] pins registered each edge; deselect and no-op decoded
// [RULE2] both-high clock enable decodes full command set
// [RULE3] bank bits pick bank; row, column split
// [RULE4] length-four bursts cannot be interrupted
// [RULE5] self refresh left asynchronously on clock enable
// [RULE6] controller bounds power-down length for refresh
// [RULE7] compare clock enable with previous edge
// [RULE8] open banks choose active or precharge power-down
// [RULE9] power-down entry, exit, hold with no-op only; code also takes deselect, and holds whatever the command
// [RULE10] self refresh entered from idle with refresh
// [RULE11] controller sends no-op at self-refresh exit
// [RULE12] controller idles through non-read exit delay
// [RULE13] controller waits two hundred clocks before read
// [RULE14] unlisted combinations are illegal, flagged only
// [RULE15] controller avoids power-down during busy operations
// [RULE16] controller holds clock enable three edges
// [RULE17] termination ignored by states, off in self refresh
// [RULE18] controller keeps clock enable high in calibration
// [RULE19] controller drives termination pin in power-down
// [RULE20] mask high inhibits its coincident write beat
// [RULE21] controller precharges all banks before refresh
// [RULE22] illegal command leaves all state unchanged; code still counts burst_q down and records the event
module dcd_top #(
    parameter int DQ_W  = dcd_pkg::DCD_DQ_W,
    parameter int LANES = dcd_pkg::DCD_LANES
) (
    // clocks and reset
    input  wire logic                 i_mclk,
    input  wire logic                 i_lclk,
    input  wire logic                 i_nrst,
    // command pins from the controller
    input  wire dcd_pkg::dcd_pins_type i_pins,
    // write data beat
    input  wire logic                 i_wbeat,
    input  wire logic [DQ_W-1:0]      i_dq,
    input  wire logic [LANES-1:0]     i_dm,
    // link-side write path
    output logic                      o_wvalid,
    output logic      [DQ_W-1:0]      o_wdata,
    output logic      [LANES-1:0]     o_wbe,
    // core-side decoded commands
    output logic                      o_cmd_valid,
    output dcd_pkg::dcd_evt_type      o_cmd,
    output logic                      o_illegal,
    output dcd_pkg::dcd_pwr_type      o_pwr,
    output logic                      o_self_refresh,
    output logic                      o_odt_on
);
    localparam int BW = dcd_pkg::DCD_BANKS;

    // link domain state
    dcd_pkg::dcd_pins_type pins_q;
    logic                  cke_prev_q;
    dcd_pkg::dcd_pwr_type  pwr_q;
    dcd_pkg::dcd_pwr_type  pwr_d;
    logic [BW-1:0]         open_q;
    logic [BW-1:0]         open_d;
    logic [1:0]            burst_q;
    logic                  sr_q;
    logic                  tog_q;
    dcd_pkg::dcd_evt_type  evt_q;

    // pin capture
    always_ff @(posedge i_lclk or negedge i_nrst) begin
        if (!i_nrst) begin
            pins_q     <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
                            we_n: 1'b1, default: '0};
            cke_prev_q <= 1'b0;
        end else begin
            pins_q     <= i_pins; // RULE1
            cke_prev_q <= pins_q.cke; // RULE7
        end
    end

    // command field decode
    wire [3:0] enc = {pins_q.cs_n, pins_q.ras_n, pins_q.cas_n,
                      pins_q.we_n};
    wire is_dsl   = pins_q.cs_n; // RULE1
    wire is_nop   = !pins_q.cs_n && enc == dcd_pkg::DCD_ENC_NOP; // RULE1
    wire idle_cmd = is_dsl || is_nop;
    wire ap       = pins_q.addr[dcd_pkg::DCD_AP_BIT]; // RULE2
    wire [dcd_pkg::DCD_COL_W-1:0] col =
        {pins_q.addr[dcd_pkg::DCD_ADDR_W-1:dcd_pkg::DCD_AP_BIT+1],
         pins_q.addr[dcd_pkg::DCD_AP_BIT-1:0]}; // RULE3
    wire bank_open = open_q[pins_q.ba]; // RULE3
    wire all_idle  = ~|open_q;
    wire busy      = burst_q != 2'h0;

    // clock-enable transitions against the previous edge
    wire cke_hh   = cke_prev_q && pins_q.cke; // RULE7
    wire cke_fall = cke_prev_q && !pins_q.cke; // RULE7
    wire cke_rise = !cke_prev_q && pins_q.cke; // RULE7
    wire normal   = pwr_q == dcd_pkg::DCD_PWR_NORMAL;
    wire in_pd    = pwr_q == dcd_pkg::DCD_PWR_PD_PRE ||
                    pwr_q == dcd_pkg::DCD_PWR_PD_ACT;
    wire in_self  = pwr_q == dcd_pkg::DCD_PWR_SELF;

    // a burst owns the bus until its last beat; no cut-in allowed
    wire is_enc_act = !is_dsl && enc == dcd_pkg::DCD_ENC_ACT;
    wire is_enc_pre = !is_dsl && enc == dcd_pkg::DCD_ENC_PRE;
    wire is_enc_wr  = !is_dsl && enc == dcd_pkg::DCD_ENC_WR;
    wire is_enc_rd  = !is_dsl && enc == dcd_pkg::DCD_ENC_RD;
    wire is_enc_mrs = !is_dsl && enc == dcd_pkg::DCD_ENC_MRS;
    wire is_enc_ref = !is_dsl && enc == dcd_pkg::DCD_ENC_REF;

    wire dcd_pkg::dcd_cmd_type hh_cmd =
        is_dsl ? dcd_pkg::DCD_CMD_DSL :
        is_nop ? dcd_pkg::DCD_CMD_NOP :
        busy   ? dcd_pkg::DCD_CMD_ILL : // RULE4
        (is_enc_act && !bank_open) ? dcd_pkg::DCD_CMD_ACT : // RULE2
        is_enc_pre ? (ap ? dcd_pkg::DCD_CMD_PREA
                         : dcd_pkg::DCD_CMD_PRE) : // RULE2
        (is_enc_wr && bank_open) ? (ap ? dcd_pkg::DCD_CMD_WRA
                                       : dcd_pkg::DCD_CMD_WR) :
        (is_enc_rd && bank_open) ? (ap ? dcd_pkg::DCD_CMD_RDA
                                       : dcd_pkg::DCD_CMD_RD) :
        (is_enc_mrs && all_idle) ? dcd_pkg::DCD_CMD_MRS :
        (is_enc_ref && all_idle) ? dcd_pkg::DCD_CMD_REF :
        dcd_pkg::DCD_CMD_ILL; // RULE14

    wire dcd_pkg::dcd_cmd_type fall_cmd =
        busy ? dcd_pkg::DCD_CMD_ILL :
        idle_cmd ? dcd_pkg::DCD_CMD_PDE : // RULE9
        (is_enc_ref && all_idle) ? dcd_pkg::DCD_CMD_SRE : // RULE10
        dcd_pkg::DCD_CMD_ILL;

    // power-down holds on clock enable low, whatever the command
    wire dcd_pkg::dcd_cmd_type pd_cmd =
        !pins_q.cke ? dcd_pkg::DCD_CMD_NOP : // RULE9
        idle_cmd    ? dcd_pkg::DCD_CMD_PDX : // RULE9
        dcd_pkg::DCD_CMD_ILL;

    // self refresh: the core side has already seen the exit
    wire dcd_pkg::dcd_cmd_type sr_cmd =
        pins_q.cke ? dcd_pkg::DCD_CMD_SRX : dcd_pkg::DCD_CMD_NOP;

    wire dcd_pkg::dcd_cmd_type cmd_d =
        in_self ? sr_cmd :
        in_pd   ? pd_cmd :
        cke_hh  ? hh_cmd :
        cke_fall ? fall_cmd :
        cke_rise ? dcd_pkg::DCD_CMD_ILL :
        dcd_pkg::DCD_CMD_NOP;

    wire is_rw = cmd_d == dcd_pkg::DCD_CMD_RD ||
                 cmd_d == dcd_pkg::DCD_CMD_RDA ||
                 cmd_d == dcd_pkg::DCD_CMD_WR ||
                 cmd_d == dcd_pkg::DCD_CMD_WRA;
    wire emit  = cmd_d != dcd_pkg::DCD_CMD_NOP &&
                 cmd_d != dcd_pkg::DCD_CMD_DSL;

    // next power state; the state before the edge picks the kind
    assign pwr_d =
        cmd_d == dcd_pkg::DCD_CMD_PDE ?
            (all_idle ? dcd_pkg::DCD_PWR_PD_PRE
                      : dcd_pkg::DCD_PWR_PD_ACT) : // RULE8
        cmd_d == dcd_pkg::DCD_CMD_SRE ? dcd_pkg::DCD_PWR_SELF : // RULE10
        (cmd_d == dcd_pkg::DCD_CMD_PDX ||
         cmd_d == dcd_pkg::DCD_CMD_SRX) ? dcd_pkg::DCD_PWR_NORMAL :
        pwr_q; // RULE22

    // auto precharge closes the row at once; timing is not modelled
    wire [BW-1:0] ba_bit = BW'(1) << pins_q.ba;
    assign open_d =
        cmd_d == dcd_pkg::DCD_CMD_ACT  ? (open_q | ba_bit) :
        cmd_d == dcd_pkg::DCD_CMD_PREA ? '0 :
        (cmd_d == dcd_pkg::DCD_CMD_PRE ||
         cmd_d == dcd_pkg::DCD_CMD_RDA ||
         cmd_d == dcd_pkg::DCD_CMD_WRA) ? (open_q & ~ba_bit) :
        open_q; // RULE22

    wire [1:0] burst_d = is_rw ? 2'(dcd_pkg::DCD_BL_HOLD) :
                         busy  ? burst_q - 2'h1 : 2'h0; // RULE4

    always_ff @(posedge i_lclk or negedge i_nrst) begin
        if (!i_nrst) begin
            pwr_q   <= dcd_pkg::DCD_PWR_NORMAL;
            open_q  <= '0;
            burst_q <= 2'h0;
            sr_q    <= 1'b0;
        end else begin
            pwr_q   <= pwr_d;
            open_q  <= open_d;
            burst_q <= burst_d;
            sr_q    <= pwr_d == dcd_pkg::DCD_PWR_SELF;
        end
    end

    // event word stays put until the next event, so the core can
    // sample it after the toggle lands
    always_ff @(posedge i_lclk or negedge i_nrst) begin
        if (!i_nrst) begin
            tog_q <= 1'b0;
            evt_q <= '0;
        end else if (emit) begin
            tog_q <= ~tog_q;
            evt_q <= '{cmd: cmd_d, pwr: pwr_d, ba: pins_q.ba,
                       row: pins_q.addr, col: col, ap: ap}; // RULE3
        end
    end

    dcd_wmask #(
        .DQ_W  (DQ_W),
        .LANES (LANES)
    ) u_wmask (
        .i_clk     (i_lclk),
        .i_nrst    (i_nrst),
        .i_valid   (i_wbeat),
        .i_dq      (i_dq),
        .i_dm      (i_dm),
        .o_valid_q (o_wvalid),
        .o_data_q  (o_wdata),
        .o_be_q    (o_wbe)
    );

    // core domain
    logic [3:0] sync_s;
    dcd_sync #(
        .W (4)
    ) u_sync (
        .i_clk  (i_mclk),
        .i_nrst (i_nrst),
        .i_d    ({tog_q, i_pins.cke, i_pins.odt, sr_q}),
        .o_q    (sync_s)
    );
    wire tog_s = sync_s[3];
    wire cke_s = sync_s[2];
    wire odt_s = sync_s[1];
    wire sr_s  = sync_s[0];

    logic tog_seen_q;
    wire  tog_new = tog_s ^ tog_seen_q;
    // the pin, not the link clock, ends self refresh
    wire  self_d  = sr_s && !cke_s; // RULE5
    wire  odt_d   = odt_s && !self_d; // RULE17

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            tog_seen_q     <= 1'b0;
            o_cmd_valid    <= 1'b0;
            o_illegal      <= 1'b0;
            o_cmd          <= '0;
            o_pwr          <= dcd_pkg::DCD_PWR_NORMAL;
            o_self_refresh <= 1'b0;
            o_odt_on       <= 1'b0;
        end else begin
            tog_seen_q     <= tog_s;
            o_cmd_valid    <= tog_new;
            o_illegal      <= tog_new &&
                              evt_q.cmd == dcd_pkg::DCD_CMD_ILL; // RULE14
            o_self_refresh <= self_d; // RULE5
            o_odt_on       <= odt_d; // RULE17
            if (tog_new) begin
                o_cmd <= evt_q;
                o_pwr <= evt_q.pwr;
            end
        end
    end

    // checks on the link side, plus core-side checks on i_mclk
    sequence s_idle_fall;
        normal && cke_fall && idle_cmd && !busy;
    endsequence

    sequence s_any_open;
        |open_q;
    endsequence

    sequence s_self_entry;
        normal && cke_fall && is_enc_ref && all_idle && !busy;
    endsequence

    chk_dsl_decode: assert property ( // RULE1
        @(posedge i_lclk) disable iff (!i_nrst)
        normal && cke_hh && pins_q.cs_n |-> cmd_d == dcd_pkg::DCD_CMD_DSL)
        else $error("deselect not decoded");

    chk_act_opens: assert property ( // RULE3
        @(posedge i_lclk) disable iff (!i_nrst)
        normal && cke_hh && is_enc_act && !bank_open && !busy
        |=> open_q[$past(pins_q.ba)])
        else $error("activate did not open its bank");

    chk_prea_closes: assert property ( // RULE2
        @(posedge i_lclk) disable iff (!i_nrst)
        normal && cke_hh && is_enc_pre && ap && !busy |=> open_q == '0)
        else $error("precharge all left a bank open");

    chk_burst_hold: assert property ( // RULE4
        @(posedge i_lclk) disable iff (!i_nrst)
        is_rw |=> !is_rw ##1 !busy)
        else $error("burst interrupted or hold wrong");

    chk_pd_kind: assert property ( // RULE8
        @(posedge i_lclk) disable iff (!i_nrst)
        s_idle_fall and s_any_open |=> pwr_q == dcd_pkg::DCD_PWR_PD_ACT)
        else $error("wrong power-down kind");

    chk_pd_holds: assert property ( // RULE9
        @(posedge i_lclk) disable iff (!i_nrst)
        in_pd && !pins_q.cke |=> $stable(pwr_q) && in_pd)
        else $error("power-down left with clock enable low");

    chk_sre_idle: assert property ( // RULE10
        @(posedge i_lclk) disable iff (!i_nrst)
        (normal && cke_fall && is_enc_ref) and s_any_open
        |=> pwr_q != dcd_pkg::DCD_PWR_SELF)
        else $error("self refresh entered with a bank open");

    chk_ill_keeps: assert property ( // RULE22
        @(posedge i_lclk) disable iff (!i_nrst)
        cmd_d == dcd_pkg::DCD_CMD_ILL |=> $stable(pwr_q) && $stable(open_q))
        else $error("illegal command changed state");

    chk_sr_exit_async: assert property ( // RULE5
        @(posedge i_mclk) disable iff (!i_nrst)
        sr_s && cke_s |=> !o_self_refresh)
        else $error("self refresh not left on clock enable");

    chk_odt_gated: assert property ( // RULE17
        @(posedge i_mclk) disable iff (!i_nrst)
        sr_s && !cke_s && odt_s |=> o_self_refresh && !o_odt_on)
        else $error("termination on in self refresh");

    chk_nop_decode: assert property ( // RULE1
        @(posedge i_lclk) disable iff (!i_nrst)
        normal && cke_hh && is_nop |-> cmd_d == dcd_pkg::DCD_CMD_NOP)
        else $error("no-operation not decoded");

    chk_sre_entry: assert property ( // RULE10
        @(posedge i_lclk) disable iff (!i_nrst)
        s_self_entry |=> in_self && sr_q)
        else $error("self refresh not entered");

    chk_self_holds: assert property ( // RULE10
        @(posedge i_lclk) disable iff (!i_nrst)
        in_self && !pins_q.cke |=> in_self)
        else $error("self refresh left with clock enable low");

    chk_pd_exit: assert property ( // RULE9
        @(posedge i_lclk) disable iff (!i_nrst)
        in_pd && pins_q.cke && idle_cmd |=> normal)
        else $error("power-down not left on clock enable high");

    chk_pd_pre_kind: assert property ( // RULE8
        @(posedge i_lclk) disable iff (!i_nrst)
        s_idle_fall and all_idle |=> pwr_q == dcd_pkg::DCD_PWR_PD_PRE)
        else $error("wrong idle power-down kind");

    chk_illegal_pulse: assert property ( // RULE14
        @(posedge i_mclk) disable iff (!i_nrst)
        o_illegal
        |-> o_cmd_valid && o_cmd.cmd == dcd_pkg::DCD_CMD_ILL)
        else $error("illegal flag without illegal event");
endmodule
`default_nettype wire

// file: dv/dcd_ctl_model.sv
// dcd_ctl_model: behavioural memory controller on the command pins
// assumes: bench calls send(); pins change just after rising i_lclk
`timescale 1ns/1ps
`default_nettype none
module dcd_ctl_model (
    // link clock and termination level
    input  wire logic             i_lclk,
    input  wire logic             i_odt,
    // command pins
    output dcd_pkg::dcd_pins_type o_pins
);
    logic self_q = 1'b0;

    initial begin
        o_pins = '0;
        o_pins.cs_n = 1'b1;
    end

    // bench never closes an open burst, busy op or open bank early
    task automatic send(input logic [3:0]  enc,
                        input logic        cke,
                        input logic [2:0]  ba,
                        input logic [12:0] a);
        dcd_pkg::dcd_pins_type p;
        logic [3:0]            e;
        int                    n;
        e = enc;
        n = (cke != o_pins.cke) ? 3 : 1;
        if (self_q && cke) begin
            n = 201;
        end
        self_q = cke ? 1'b0 : (self_q || (o_pins.cke && enc == 4'h1));
        for (int i = 0; i < n; i++) begin
            @(posedge i_lclk);
            p = o_pins;
            p.cke = cke;
            p.odt = i_odt;
            p.cs_n = e[3];
            // released lines flip so a stale value never looks valid
            if (e[3]) begin
                {p.ras_n, p.cas_n, p.we_n} = ~{p.ras_n, p.cas_n, p.we_n};
            end else begin
                {p.ras_n, p.cas_n, p.we_n} = e[2:0];
            end
            if (e[3] || e == dcd_pkg::DCD_ENC_NOP) begin
                p.ba = ~p.ba;
                p.addr = ~p.addr;
            end else begin
                p.ba = ba;
                p.addr = a;
            end
            o_pins <= p;
            e = dcd_pkg::DCD_ENC_NOP;
        end
    endtask
endmodule
`default_nettype wire

// file: dv/dcd_top_tb_top.sv
// dcd_top_tb_top: self-checking bench for the command decoder
// assumes: dcd_ctl_model drives pins; lclk 48 ns, mclk 8 ns
`timescale 1ns/1ps
`default_nettype none
module dcd_top_tb_top;
    localparam logic [3:0] NOP = dcd_pkg::DCD_ENC_NOP;
    localparam logic [3:0] DSL = 4'h8;
    logic                  i_mclk = 1'b0;
    logic                  i_lclk = 1'b0;
    logic                  i_nrst = 1'b0;
    logic                  i_wbeat = 1'b0;
    logic                  odt = 1'b0;
    logic [15:0]           i_dq = 16'h0000;
    logic [1:0]            i_dm = 2'h0;
    dcd_pkg::dcd_pins_type pins;
    logic                  o_wvalid;
    logic [15:0]           o_wdata;
    logic [1:0]            o_wbe;
    logic                  o_cmd_valid;
    dcd_pkg::dcd_evt_type  o_cmd;
    logic                  o_illegal;
    dcd_pkg::dcd_pwr_type  o_pwr;
    logic                  o_self_refresh;
    logic                  o_odt_on;
    logic [35:0]           evq[$];
    dcd_pkg::dcd_evt_type  e;
    int                    checks = 0;
    int                    mismatches = 0;
    int                    cycles = 0;

    dcd_top u_dcd_top (.i_mclk(i_mclk), .i_lclk(i_lclk), .i_nrst(i_nrst),
        .i_pins(pins), .i_wbeat(i_wbeat), .i_dq(i_dq), .i_dm(i_dm),
        .o_wvalid(o_wvalid), .o_wdata(o_wdata), .o_wbe(o_wbe),
        .o_cmd_valid(o_cmd_valid), .o_cmd(o_cmd), .o_illegal(o_illegal),
        .o_pwr(o_pwr), .o_self_refresh(o_self_refresh),
        .o_odt_on(o_odt_on));
    dcd_ctl_model u_dcd_ctl_model (.i_lclk(i_lclk), .i_odt(odt),
        .o_pins(pins));

    initial begin
        forever #4 i_mclk = ~i_mclk;
    end
    initial begin
        #7;
        forever #24 i_lclk = ~i_lclk;
    end
    // event pulses last one mclk, so they are queued where they stand
    always @(posedge i_mclk) begin
        cycles++;
        if (o_cmd_valid === 1'b1) begin
            evq.push_back({o_illegal, o_cmd});
        end
        if (cycles > 12000) begin
            mismatches++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cmd(input logic [3:0] c, input logic k,
                       input logic [2:0] ba, input logic [12:0] a);
        u_dcd_ctl_model.send(c, k, ba, a);
        u_dcd_ctl_model.send(NOP, k, 3'h0, 13'h0000);
    endtask

    task automatic get_evt(input dcd_pkg::dcd_cmd_type c,
                           output dcd_pkg::dcd_evt_type ev);
        logic [35:0] w;
        w = '0;
        for (int i = 0; i < 60 && evq.size() == 0; i++) begin
            @(posedge i_mclk);
        end
        check(evq.size() != 0, 1'b1);
        if (evq.size() != 0) begin
            w = evq.pop_front();
        end
        ev = w[34:0];
        check({w[35], ev.cmd}, {c == dcd_pkg::DCD_CMD_ILL, c});
    endtask

    task automatic no_evt();
        repeat (30) @(posedge i_mclk);
        check(evq.size(), 0);
    endtask

    task automatic s_decode();
        cmd(DSL, 1'b1, 3'h1, 13'h0001);
        no_evt();
        cmd(dcd_pkg::DCD_ENC_ACT, 1'b1, 3'h3, 13'h1abc);
        get_evt(dcd_pkg::DCD_CMD_ACT, e);
        check({e.ba, e.row}, {3'h3, 13'h1abc});
        u_dcd_ctl_model.send(dcd_pkg::DCD_ENC_RD, 1'b1, 3'h3, 13'h1c05);
        cmd(dcd_pkg::DCD_ENC_ACT, 1'b1, 3'h4, 13'h0000);
        get_evt(dcd_pkg::DCD_CMD_RDA, e);
        check({e.ba, e.ap, e.col}, {3'h3, 1'b1, 12'hc05});
        get_evt(dcd_pkg::DCD_CMD_ILL, e);
        cmd(dcd_pkg::DCD_ENC_ACT, 1'b1, 3'h5, 13'h0010);
        get_evt(dcd_pkg::DCD_CMD_ACT, e);
        cmd(dcd_pkg::DCD_ENC_ACT, 1'b1, 3'h5, 13'h0020);
        get_evt(dcd_pkg::DCD_CMD_ILL, e);
        cmd(dcd_pkg::DCD_ENC_MRS, 1'b1, 3'h2, 13'h0000);
        get_evt(dcd_pkg::DCD_CMD_ILL, e);
        cmd(dcd_pkg::DCD_ENC_WR, 1'b1, 3'h5, 13'h0804);
        get_evt(dcd_pkg::DCD_CMD_WR, e);
        check({e.ba, e.ap, e.col}, {3'h5, 1'b0, 12'h404});
        cmd(dcd_pkg::DCD_ENC_PRE, 1'b1, 3'h5, 13'h0000);
        get_evt(dcd_pkg::DCD_CMD_PRE, e);
        check(e.ba, 3'h5);
        cmd(dcd_pkg::DCD_ENC_MRS, 1'b1, 3'h2, 13'h0042);
        get_evt(dcd_pkg::DCD_CMD_MRS, e);
        check({e.ba, e.row}, {3'h2, 13'h0042});
        cmd(dcd_pkg::DCD_ENC_REF, 1'b1, 3'h0, 13'h0000);
        get_evt(dcd_pkg::DCD_CMD_REF, e);
    endtask

    task automatic s_power();
        cmd(dcd_pkg::DCD_ENC_ACT, 1'b1, 3'h0, 13'h0007);
        get_evt(dcd_pkg::DCD_CMD_ACT, e);
        cmd(NOP, 1'b0, 3'h0, 13'h0000);
        get_evt(dcd_pkg::DCD_CMD_PDE, e);
        check(e.pwr, dcd_pkg::DCD_PWR_PD_ACT);
        cmd(dcd_pkg::DCD_ENC_ACT, 1'b0, 3'h1, 13'h0000);
        no_evt();
        check(o_pwr, dcd_pkg::DCD_PWR_PD_ACT);
        cmd(NOP, 1'b1, 3'h0, 13'h0000);
        get_evt(dcd_pkg::DCD_CMD_PDX, e);
        check(e.pwr, dcd_pkg::DCD_PWR_NORMAL);
        cmd(dcd_pkg::DCD_ENC_PRE, 1'b1, 3'h0, 13'h0400);
        get_evt(dcd_pkg::DCD_CMD_PREA, e);
        cmd(DSL, 1'b0, 3'h0, 13'h0000);
        get_evt(dcd_pkg::DCD_CMD_PDE, e);
        check(e.pwr, dcd_pkg::DCD_PWR_PD_PRE);
        cmd(DSL, 1'b1, 3'h0, 13'h0000);
        get_evt(dcd_pkg::DCD_CMD_PDX, e);
    endtask

    task automatic s_self();
        cmd(dcd_pkg::DCD_ENC_REF, 1'b0, 3'h0, 13'h0000);
        get_evt(dcd_pkg::DCD_CMD_SRE, e);
        check({e.pwr, o_self_refresh}, {dcd_pkg::DCD_PWR_SELF, 1'b1});
        @(posedge i_mclk);
        odt <= 1'b1;
        u_dcd_ctl_model.send(NOP, 1'b0, 3'h0, 13'h0000);
        repeat (20) @(posedge i_mclk);
        check(o_odt_on, 1'b0);
        fork
            u_dcd_ctl_model.send(NOP, 1'b1, 3'h0, 13'h0000);
            begin
                @(posedge pins.cke);
                repeat (5) @(posedge i_mclk);
                check(o_self_refresh, 1'b0);
            end
        join
        get_evt(dcd_pkg::DCD_CMD_SRX, e);
        check({e.pwr, o_odt_on}, {dcd_pkg::DCD_PWR_NORMAL, 1'b1});
        @(posedge i_mclk);
        odt <= 1'b0;
    endtask

    task automatic s_wmask();
        @(posedge i_lclk);
        i_wbeat <= 1'b1;
        i_dq <= 16'ha55a;
        i_dm <= 2'h1;
        @(posedge i_lclk);
        i_dq <= 16'h3cc3;
        i_dm <= 2'h2;
        #1;
        check({o_wvalid, o_wbe, o_wdata}, {1'b1, 2'h2, 16'ha55a});
        @(posedge i_lclk);
        i_wbeat <= 1'b0;
        #1;
        check({o_wvalid, o_wbe, o_wdata}, {1'b1, 2'h1, 16'h3cc3});
        @(posedge i_lclk);
        #1;
        check(o_wvalid, 1'b0);
    endtask

    initial begin
        repeat (12) @(posedge i_mclk);
        i_nrst <= 1'b1;
        cmd(NOP, 1'b1, 3'h0, 13'h0000);
        repeat (20) @(posedge i_mclk);
        evq.delete();
        s_decode();
        s_power();
        s_self();
        s_wmask();
        complete_run();
    end
endmodule
`default_nettype wire
